// File: logic/ssac_ctrl.v
// input-side control of a pipelined synchronous burst sram
// assumes all control pins come from another clock domain and are double synced
`timescale 1ns/1ps
`include "ssac_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - capture address when a strobe is low and all three selects active
// - on capture, load low two address bits into the 2-bit burst counter
// - lane write selects sampled on rising edge, active low
// - global write low writes every lane, ignoring lane selects and gate
// - lane selects apply only while the byte write gate is low
// - both strobes low honours processor strobe; ignored when first select high
// - second select active high, third active low, with the first
// - burst advance low during a burst increments the burst counter
// - burst-order strap low gives linear order, high gives interleaved
module ssac_ctrl (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire [19:0] addr_in,
  input wire proc_addr_strobe_n_in,
  input wire ctrl_addr_strobe_n_in,
  input wire chip_sel_first_n_in,
  input wire chip_sel_second_in,
  input wire chip_sel_third_n_in,
  input wire lane0_write_sel_n_in,
  input wire lane1_write_sel_n_in,
  input wire lane2_write_sel_n_in,
  input wire lane3_write_sel_n_in,
  input wire lane_write_gate_n_in,
  input wire all_lanes_write_n_in,
  input wire burst_advance_n_in,
  input wire burst_order_in,
  output reg [19:0] addr_out,
  output wire [1:0] burst_addr_out,
  output reg [3:0] lane_write_en_out,
  output reg read_out,
  output reg write_out,
  output reg burst_active_out,
  output reg proc_strobe_taken_out
);
  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers; the first stage feeds only the second
  localparam SYNC_W = 33;
  wire [SYNC_W-1:0] raw;
  reg [SYNC_W-1:0] sync_a;
  reg [SYNC_W-1:0] sync_b;
  assign raw = {addr_in, proc_addr_strobe_n_in, ctrl_addr_strobe_n_in,
    chip_sel_first_n_in, chip_sel_second_in, chip_sel_third_n_in,
    lane3_write_sel_n_in, lane2_write_sel_n_in, lane1_write_sel_n_in,
    lane0_write_sel_n_in, lane_write_gate_n_in, all_lanes_write_n_in,
    burst_advance_n_in, burst_order_in};
  genvar i;
  generate
    for (i = 0; i < SYNC_W; i = i + 1)
    begin : g_sync
      always @(posedge sys_clk_in)
      begin
        sync_a[i] <= raw[i];
        sync_b[i] <= sync_a[i];
      end
    end
  endgenerate
  wire [19:0] s_addr = sync_b[32:13];
  wire s_proc_n = sync_b[12];
  wire s_ctrl_n = sync_b[11];
  wire s_cs1_n = sync_b[10];
  wire s_cs2 = sync_b[9];
  wire s_cs3_n = sync_b[8];
  wire [3:0] s_lane_n = sync_b[7:4];
  wire s_gate_n = sync_b[3];
  wire s_all_n = sync_b[2];
  wire s_adv_n = sync_b[1];
  wire s_order = sync_b[0];

  ////////////////////////////////////////////////////////////////////////////
  // selection and strobe decode
  wire selected = !s_cs1_n && s_cs2 && !s_cs3_n;
  // processor strobe wins over controller strobe even with first select high, but is taken only with first select low
  wire proc_take = !s_proc_n && !s_cs1_n;
  wire ctrl_take = !s_ctrl_n && s_proc_n;
  wire capture = (proc_take || ctrl_take) && selected;
  wire advance = !capture && burst_active_out && !s_adv_n;

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  reg [3:0] next_lanes;
  always @*
  begin
    if (!s_all_n)
      next_lanes = `SSAC_ALL_LANES;
    else if (!s_gate_n)
      next_lanes = ~s_lane_n;
    else
      next_lanes = `SSAC_NO_LANES;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      addr_out <= `SSAC_ADDR_RST;
      lane_write_en_out <= `SSAC_NO_LANES;
      read_out <= 1'b0;
      write_out <= 1'b0;
      burst_active_out <= 1'b0;
      proc_strobe_taken_out <= 1'b0;
    end
    else
    begin
      if (capture)
        addr_out <= s_addr;
      proc_strobe_taken_out <= capture && proc_take;
      if (capture)
        burst_active_out <= 1'b1;
      else if (!s_proc_n && s_cs1_n)
        burst_active_out <= burst_active_out;
      else if ((!s_ctrl_n) && !selected)
        burst_active_out <= 1'b0;
      // writes happen on a capture or on a burst continuation cycle
      if (capture || burst_active_out)
      begin
        lane_write_en_out <= next_lanes;
        write_out <= (next_lanes != `SSAC_NO_LANES);
        read_out <= (next_lanes == `SSAC_NO_LANES);
      end
      else
      begin
        lane_write_en_out <= `SSAC_NO_LANES;
        write_out <= 1'b0;
        read_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst counter; strap is static so it is used straight from the synchroniser
  ssac_burst_seq u_burst (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .load_in(capture),
    .seed_in(s_addr[1:0]),
    .advance_in(advance),
    .interleave_in(s_order),
    .burst_addr_out(burst_addr_out)
  );
endmodule // ssac_ctrl

// File: include/ssac_regs.vh
// constants for the synchronous sram address and write control block
// assumes inclusion by bare name from the design files
`ifndef SSAC_REGS_VH
`define SSAC_REGS_VH
`define SSAC_LANES 4
`define SSAC_ADDR_W 20
`define SSAC_BURST_W 2
`define SSAC_ALL_LANES 4'hF
`define SSAC_NO_LANES 4'h0
`define SSAC_BURST_RST 2'h0
`define SSAC_ADDR_RST 20'h00000
`define SSAC_CYC_IDLE 2'h0
`define SSAC_CYC_READ 2'h1
`define SSAC_CYC_WRITE 2'h2
`endif

// File: logic/ssac_burst_seq.v
// burst address sequencer: 2-bit counter and linear/interleaved order
// assumes load and advance are already qualified by the parent
`timescale 1ns/1ps
`include "ssac_regs.vh"
module ssac_burst_seq (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire load_in,
  input wire [1:0] seed_in,
  input wire advance_in,
  input wire interleave_in,
  output wire [1:0] burst_addr_out
);
  reg [1:0] seed;
  reg [1:0] count;
  // linear step is summed one bit wider and cut back on purpose, so the wrap is explicit
  wire [2:0] lin_sum = {1'b0, seed} + {1'b0, count};
  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      seed <= `SSAC_BURST_RST;
      count <= `SSAC_BURST_RST;
    end
    else if (load_in)
    begin
      seed <= seed_in;
      count <= `SSAC_BURST_RST;
    end
    else if (advance_in)
      count <= count + 2'h1;
  end
  // interleaved order xors the step into the seed, linear order adds it
  assign burst_addr_out = interleave_in ? (seed ^ count) : lin_sum[1:0];
endmodule // ssac_burst_seq

// File: tb/ssac_ctrl_sva.sv
// assertions on the sram address and write control ports
// assumes a bind from the bench top, pins sampled 3 edges before
`timescale 1ns/1ps
module ssac_ctrl_sva (
  input wire sys_clk_in, nrst_in,
  input wire [19:0] addr_in, addr_out,
  input wire proc_addr_strobe_n_in, ctrl_addr_strobe_n_in,
  input wire chip_sel_first_n_in, chip_sel_second_in, chip_sel_third_n_in,
  input wire lane0_write_sel_n_in, lane1_write_sel_n_in, lane2_write_sel_n_in,
  input wire lane3_write_sel_n_in, lane_write_gate_n_in, all_lanes_write_n_in,
  input wire [1:0] burst_addr_out,
  input wire [3:0] lane_write_en_out,
  input wire read_out, write_out, proc_strobe_taken_out
);
  wire sel = !chip_sel_first_n_in && chip_sel_second_in && !chip_sel_third_n_in;
  wire cap = sel && !(proc_addr_strobe_n_in && ctrl_addr_strobe_n_in);
  wire [3:0] lan = ~{lane3_write_sel_n_in, lane2_write_sel_n_in, lane1_write_sel_n_in,
    lane0_write_sel_n_in};
  wire gw = !all_lanes_write_n_in;
  wire gt = !lane_write_gate_n_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////
  addr_cap_a: assert property (cap |-> ##3 addr_out == $past(addr_in, 3))
    else $error("address not captured");
  addr_hold_a: assert property (!cap |-> ##3 $stable(addr_out))
    else $error("address moved without capture");
  burst_seed_a: assert property (cap |-> ##3 burst_addr_out == $past(addr_in[1:0], 3))
    else $error("burst seed wrong");
  all_lanes_a: assert property (cap && gw |-> ##3 lane_write_en_out == 4'hF)
    else $error("global write missed a lane");
  byte_lanes_a: assert property (
    cap && !gw && gt |-> ##3 lane_write_en_out == $past(lan, 3))
    else $error("lane enables wrong");
  read_only_a: assert property (
    cap && !gw && (!gt || lan == 4'h0) |-> ##3 read_out && lane_write_en_out == 4'h0)
    else $error("read cycle wrote");
  proc_first_a: assert property (
    cap |-> ##3 proc_strobe_taken_out != $past(proc_addr_strobe_n_in, 3))
    else $error("strobe priority wrong");
  write_flag_a: assert property (cap |-> ##3 write_out == (lane_write_en_out != 4'h0))
    else $error("write flag wrong");
  cover property (cap && gw);
  cover property (cap && !gw && gt);
  cover property (!sel && !ctrl_addr_strobe_n_in);
endmodule // ssac_ctrl_sva

// File: tb/ssac_master.sv
// bus master model for the sram control pins
// assumes the bench calls cyc at most once a clock
`timescale 1ns/1ps
module ssac_master (
  input wire sys_clk_in,
  output reg [19:0] addr_in,
  output wire proc_addr_strobe_n_in, ctrl_addr_strobe_n_in, chip_sel_first_n_in,
  output wire chip_sel_second_in, chip_sel_third_n_in, lane3_write_sel_n_in,
  output wire lane2_write_sel_n_in, lane1_write_sel_n_in, lane0_write_sel_n_in,
  output wire lane_write_gate_n_in, all_lanes_write_n_in, burst_advance_n_in, burst_order_in
);
  reg [12:0] pins = 13'h1DFE;
  initial addr_in = 20'h00000;
  assign {proc_addr_strobe_n_in, ctrl_addr_strobe_n_in, chip_sel_first_n_in, chip_sel_second_in,
    chip_sel_third_n_in, lane3_write_sel_n_in, lane2_write_sel_n_in, lane1_write_sel_n_in,
    lane0_write_sel_n_in, lane_write_gate_n_in, all_lanes_write_n_in, burst_advance_n_in,
    burst_order_in} = pins;
  // pins move just after the edge and hold until the next call
  task cyc(input [19:0] a, input [12:0] c);
    begin
      @(posedge sys_clk_in);
      #1;
      addr_in = a;
      pins = c;
    end
  endtask
endmodule // ssac_master

// File: tb/ssac_ctrl_tb.sv
// self-checking bench for the sram address and write control block
// assumes answers land 3 edges after the pins change
`timescale 1ns/1ps
module ssac_ctrl_tb;
  reg sys_clk_in = 1'b0;
  reg nrst_in = 1'b0;
  wire [19:0] addr_in, addr_out;
  wire [1:0] burst_addr_out;
  wire [3:0] lane_write_en_out;
  wire proc_addr_strobe_n_in, ctrl_addr_strobe_n_in, chip_sel_first_n_in, chip_sel_second_in;
  wire chip_sel_third_n_in, lane3_write_sel_n_in, lane2_write_sel_n_in, lane1_write_sel_n_in;
  wire lane0_write_sel_n_in, lane_write_gate_n_in, all_lanes_write_n_in, burst_advance_n_in;
  wire burst_order_in, read_out, write_out, burst_active_out, proc_strobe_taken_out;
  wire [28:0] obs = {addr_out, burst_addr_out, lane_write_en_out, read_out, write_out,
    proc_strobe_taken_out};
  integer err_count = 0;
  integer n_tests = 0;
  always #25 sys_clk_in = ~sys_clk_in;
  ssac_master m (.*);
  ssac_ctrl dut (.*);
  ////////////////////////////////////////
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
    end
  endtask
  task go(input [19:0] a, input [12:0] c);
    begin
      m.cyc(a, c);
      repeat (4) @(posedge sys_clk_in);
      #2;
    end
  endtask
  // strap only changes while reset is held
  task rst(input o);
    begin
      m.cyc(20'h00000, {12'hEFF, o});
      nrst_in = 1'b0;
      repeat (2) @(posedge sys_clk_in);
      #1;
      nrst_in = 1'b1;
      check(obs, 0);
    end
  endtask
  task t_write;
    begin
      go(20'hABCDE, 13'h025A);
      check(obs, {20'hABCDE, 2'h2, 4'hF, 3'b011});
      check(burst_active_out, 1);
      go(20'h12347, 13'h1256);
      check(obs, {20'h12347, 2'h3, 4'hA, 3'b010});
    end
  endtask
  task t_read;
    begin
      go(20'h54320, 13'h120E);
      check(obs, {20'h54320, 2'h0, 4'h0, 3'b100});
      go(20'h54321, 13'h12F6);
      check(obs, {20'h54321, 2'h1, 4'h0, 3'b100});
    end
  endtask
  task t_refuse;
    begin
      go(20'hFFFFF, 13'h100E);
      check(addr_out, 20'h54321);
      check(burst_active_out, 0);
      go(20'hFFFFF, 13'h0EFE);
      check(addr_out, 20'h54321);
    end
  endtask
  task t_burst(input o, input [1:0] e);
    begin
      rst(o);
      m.cyc(20'h00001, {12'h97F, o});
      // one advance only: after one step linear and interleaved orders differ
      m.cyc(20'h00001, {12'hD7E, o});
      repeat (3) @(posedge sys_clk_in);
      #2;
      check(burst_addr_out, e);
    end
  endtask
  task conclude;
    begin
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial
  begin
    rst(1'b0);
    t_write;
    t_read;
    t_refuse;
    t_burst(1'b0, 2'h2);
    t_burst(1'b1, 2'h0);
    conclude;
  end
endmodule // ssac_ctrl_tb
bind ssac_ctrl ssac_ctrl_sva chk (.*);
